// ==== rtl/scksg_pkg.sv ====
package scksg_pkg;
   // register byte offsets (own choice, one word each)
   localparam logic [7:0] SCKSG_CTRL_OFS = 8'h00;
   localparam logic [7:0] SCKSG_STAT_OFS = 8'h04;
   // control word field positions
   localparam int SCKSG_SLOW_TYPE_BIT = 0;
   localparam int SCKSG_FAST_TYPE_BIT = 1;
   localparam int SCKSG_SRC_STOP_BIT = 2;
   localparam int SCKSG_FAST_STOP_BIT = 3;
   localparam int SCKSG_PER_STOP_BIT = 4;
   localparam int SCKSG_SYS_FAST_BIT = 5;
   // value after reset
   localparam logic [5:0] SCKSG_CTRL_RST = 6'h00;
   // power modes presented by the core
   typedef enum logic [1:0] {
      SCKSG_MODE_RUN = 2'h0,
      SCKSG_MODE_IDLE = 2'h1,
      SCKSG_MODE_POWER_DOWN_MODE = 2'h2
   } scksg_mode_t;
endpackage : scksg_pkg

// ==== rtl/scksg_gate.sv ====
`timescale 1ns/10ps
`default_nettype none
// derives the oscillator enables and clock gates from control and mode
module scksg_gate (
   input wire logic i_clk_sys,
   input wire logic i_rstn,
   input wire logic [5:0] i_ctrl,
   input wire scksg_pkg::scksg_mode_t i_mode,
   output logic o_slow_rc_en,
   output logic o_slow_xtal_en,
   output logic o_fast_rc_en,
   output logic o_fast_xtal_en,
   output logic o_xtal_pins,
   output logic o_xtal_high_gain,
   output logic o_sys_fast,
   output logic o_periph_clk_en
);
   import scksg_pkg::*;
   logic [7:0] gate_d;
   logic [7:0] gate_q;
   logic slow_type;
   logic fast_type;
   logic pd;
   logic idle;
   logic fstop;

   // combine control bits with the current mode
   always_comb begin
      slow_type = i_ctrl[SCKSG_SLOW_TYPE_BIT];
      fast_type = i_ctrl[SCKSG_FAST_TYPE_BIT];
      pd = (i_mode == SCKSG_MODE_POWER_DOWN_MODE);
      idle = (i_mode == SCKSG_MODE_IDLE);
      // fast stop bit halts fast osc only when slow clock drives system
      fstop = i_ctrl[SCKSG_FAST_STOP_BIT] & ~i_ctrl[SCKSG_SYS_FAST_BIT];
      gate_d[0] = ~slow_type & ~(pd & i_ctrl[SCKSG_SRC_STOP_BIT]);
      gate_d[1] = slow_type & ~pd;
      gate_d[2] = ~fast_type & ~fstop & ~pd;
      gate_d[3] = fast_type & ~fstop & ~pd;
      gate_d[4] = slow_type | fast_type; // crystal owns both pins
      gate_d[5] = fast_type; // high gain for fast crystal
      gate_d[6] = i_ctrl[SCKSG_SYS_FAST_BIT];
      gate_d[7] = ~(idle & i_ctrl[SCKSG_PER_STOP_BIT]);
   end

   // registered outputs
   always_ff @(posedge i_clk_sys) begin
      if (!i_rstn) begin
         gate_q <= 8'h81;
      end else begin
         gate_q <= gate_d;
      end
   end

   assign o_slow_rc_en = gate_q[0];
   assign o_slow_xtal_en = gate_q[1];
   assign o_fast_rc_en = gate_q[2];
   assign o_fast_xtal_en = gate_q[3];
   assign o_xtal_pins = gate_q[4];
   assign o_xtal_high_gain = gate_q[5];
   assign o_sys_fast = gate_q[6];
   assign o_periph_clk_en = gate_q[7];
endmodule : scksg_gate
`default_nettype wire

// ==== rtl/scksg_top.sv ====
// How it works
// - slow source type: 0 internal rc, 1 crystal; change only in fast mode
// - fast source type: 0 internal rc, 1 crystal high gain; change only in slow mode
// - slow rc stop set halts slow rc during power-down
// - peripheral stop set gates uart and timer clocks during idle
// - fast stop set halts fast oscillator in slow mode
// - system select 0 picks slow clock; changes only while fast stop is 0
// - fast stop changes only while system runs in slow mode
// - select, peripheral stop and slow rc stop reset to 0, read/write
`timescale 1ns/10ps
`default_nettype none
module scksg_top (
   input wire logic i_clk_sys,
   input wire logic i_rstn,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [7:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   input wire logic [3:0] i_pstrb,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   input wire scksg_pkg::scksg_mode_t i_mode,
   output logic o_slow_rc_en,
   output logic o_slow_xtal_en,
   output logic o_fast_rc_en,
   output logic o_fast_xtal_en,
   output logic o_xtal_pins,
   output logic o_xtal_high_gain,
   output logic o_sys_fast,
   output logic o_periph_clk_en
);
   import scksg_pkg::*;
   logic [5:0] ctrl_d;
   logic [5:0] ctrl_q;
   logic [31:0] rdata_d;
   logic [31:0] rdata_q;
   logic wr_ctrl;
   logic access;
   logic hit;
   logic [5:0] wv;
   logic cur_fast;
   logic cur_fstop;

   // apb decode: zero wait state
   assign access = i_psel & i_penable;
   assign hit = (i_paddr == SCKSG_CTRL_OFS) | (i_paddr == SCKSG_STAT_OFS);
   assign wr_ctrl = access & i_pwrite & (i_paddr == SCKSG_CTRL_OFS) & i_pstrb[0];
   assign o_pready = 1'b1;
   assign o_pslverr = access & ~hit;

   // guarded control update
   always_comb begin
      ctrl_d = ctrl_q;
      wv = i_pwdata[5:0];
      cur_fast = ctrl_q[SCKSG_SYS_FAST_BIT];
      cur_fstop = ctrl_q[SCKSG_FAST_STOP_BIT];
      if (wr_ctrl) begin
         ctrl_d[SCKSG_SRC_STOP_BIT] = wv[SCKSG_SRC_STOP_BIT];
         ctrl_d[SCKSG_PER_STOP_BIT] = wv[SCKSG_PER_STOP_BIT];
         if (cur_fast) begin
            ctrl_d[SCKSG_SLOW_TYPE_BIT] = wv[SCKSG_SLOW_TYPE_BIT];
         end
         if (!cur_fast) begin
            ctrl_d[SCKSG_FAST_TYPE_BIT] = wv[SCKSG_FAST_TYPE_BIT];
            ctrl_d[SCKSG_FAST_STOP_BIT] = wv[SCKSG_FAST_STOP_BIT];
         end
         if (!cur_fstop) begin
            ctrl_d[SCKSG_SYS_FAST_BIT] = wv[SCKSG_SYS_FAST_BIT];
         end
      end
   end

   // read data mux
   always_comb begin
      rdata_d = rdata_q;
      if (i_psel & ~i_penable & ~i_pwrite) begin
         rdata_d = 32'h0000_0000;
         if (i_paddr == SCKSG_CTRL_OFS) begin
            rdata_d[5:0] = ctrl_q;
         end else if (i_paddr == SCKSG_STAT_OFS) begin
            rdata_d[7:0] = {o_periph_clk_en, o_sys_fast, o_xtal_high_gain, o_xtal_pins,
                            o_fast_xtal_en, o_fast_rc_en, o_slow_xtal_en, o_slow_rc_en};
         end
      end
   end

   // control and read registers
   always_ff @(posedge i_clk_sys) begin
      if (!i_rstn) begin
         ctrl_q <= SCKSG_CTRL_RST;
         rdata_q <= 32'h0000_0000;
      end else begin
         ctrl_q <= ctrl_d;
         rdata_q <= rdata_d;
      end
   end

   assign o_prdata = rdata_q;

   scksg_gate u_gate (
      .i_clk_sys(i_clk_sys),
      .i_rstn(i_rstn),
      .i_ctrl(ctrl_q),
      .i_mode(i_mode),
      .o_slow_rc_en(o_slow_rc_en),
      .o_slow_xtal_en(o_slow_xtal_en),
      .o_fast_rc_en(o_fast_rc_en),
      .o_fast_xtal_en(o_fast_xtal_en),
      .o_xtal_pins(o_xtal_pins),
      .o_xtal_high_gain(o_xtal_high_gain),
      .o_sys_fast(o_sys_fast),
      .o_periph_clk_en(o_periph_clk_en)
   );
endmodule : scksg_top
`default_nettype wire

// ==== test/scksg_checker.sv ====
`timescale 1ns/10ps
`default_nettype none
module scksg_checker (
   input wire logic i_clk_sys, i_rstn, o_pready,
   input wire scksg_pkg::scksg_mode_t i_mode,
   input wire logic [31:0] o_prdata,
   input wire logic o_slow_rc_en, o_slow_xtal_en, o_fast_rc_en, o_fast_xtal_en,
   input wire logic o_xtal_pins, o_xtal_high_gain, o_sys_fast, o_periph_clk_en
);
   import scksg_pkg::*;
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (!i_rstn);
   // clock outputs against mode and control
   ready_always_a: assert property (o_pready) else $error("pready low");
   reset_vals_a: assert property ($rose(i_rstn) |-> o_slow_rc_en && o_periph_clk_en
      && !o_sys_fast && o_prdata == 32'h0) else $error("bad reset state");
   gain_pins_a: assert property (o_xtal_high_gain |-> o_xtal_pins) else $error("gain");
   one_fast_a: assert property (!(o_fast_rc_en && o_fast_xtal_en)) else $error("two");
   sys_osc_a: assert property (o_sys_fast && $past(i_mode) != SCKSG_MODE_POWER_DOWN_MODE
      |-> o_fast_rc_en || o_fast_xtal_en) else $error("fast clock off");
   power_down_mode_stop_a: assert property ($past(i_mode) == SCKSG_MODE_POWER_DOWN_MODE
      |-> !o_fast_rc_en && !o_fast_xtal_en) else $error("fast runs in power_down_mode");
   periph_run_a: assert property ($past(i_mode) != SCKSG_MODE_IDLE
      |-> o_periph_clk_en) else $error("periph gated");
   slow_run_a: assert property ($past(i_mode) != SCKSG_MODE_POWER_DOWN_MODE
      |-> o_slow_rc_en || o_slow_xtal_en) else $error("slow clock off");
   cover property (o_sys_fast);
   cover property (!o_periph_clk_en);
   cover property (!o_slow_rc_en);
endmodule : scksg_checker
bind scksg_top scksg_checker chk (.*);
`default_nettype wire

// ==== test/system_clock_select_and_gating_bench.sv ====
`timescale 1ns/10ps
`default_nettype none
module system_clock_select_and_gating_bench;
   import scksg_pkg::*;
   `define CHK(n,e,s) begin comparisons++; if ((s) !== (e)) begin fail_count++; \
      $display("[FAIL] %s exp %h got %h", n, e, s); end end
   logic i_clk_sys = 0, i_rstn = 0, i_psel = 0, i_penable = 0, i_pwrite = 0, err;
   logic [7:0] i_paddr = '0;
   logic [31:0] i_pwdata = '0, o_prdata, rd;
   logic [3:0] i_pstrb = 4'hf;
   logic o_pready, o_pslverr, o_slow_rc_en, o_slow_xtal_en, o_fast_rc_en, o_fast_xtal_en;
   logic o_xtal_pins, o_xtal_high_gain, o_sys_fast, o_periph_clk_en;
   scksg_mode_t i_mode = SCKSG_MODE_RUN;
   int fail_count = 0, comparisons = 0;
   scksg_top uut (.*);
   // free running clock
   initial forever #5 i_clk_sys = ~i_clk_sys;
   task automatic end_of_test();
      $display("checks %0d fails %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : end_of_test
   // one apb transfer, then an idle edge
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      i_psel <= 1'b1;
      i_pwrite <= w;
      i_paddr <= a;
      i_pwdata <= d;
      @(posedge i_clk_sys);
      i_penable <= 1'b1;
      for (n = 0; n < 9; n++) begin
         @(posedge i_clk_sys);
         if (o_pready === 1'b1) break;
      end
      rd = o_prdata;
      err = o_pslverr;
      i_psel <= 1'b0;
      i_penable <= 1'b0;
      if (n == 9) begin
         fail_count++;
         end_of_test();
      end
      @(posedge i_clk_sys);
   endtask : xfer
   // write control, let gate outputs settle, read back
   task automatic wr(input logic [5:0] d);
      xfer(1'b1, 8'h00, {26'h0, d});
      repeat (2) @(posedge i_clk_sys);
      xfer(1'b0, 8'h00, 32'h0);
   endtask : wr
   task automatic md(input scksg_mode_t m);
      i_mode <= m;
      repeat (2) @(posedge i_clk_sys);
   endtask : md
   task automatic t_reset();
      xfer(1'b0, 8'h00, 32'h0);
      `CHK("ctrl", 6'h00, rd[5:0])
      xfer(1'b0, 8'h04, 32'h0);
      // ctrl 0 leaves fast rc running once the gate register leaves reset
      `CHK("stat", 8'h85, rd[7:0])
      `CHK("frc", 1'b1, o_fast_rc_en)
      `CHK("sxt", 1'b0, o_slow_xtal_en)
      xfer(1'b0, 8'h08, 32'h0);
      `CHK("slverr", 1'b1, err)
   endtask : t_reset
   task automatic t_slow();
      wr(6'h0b);
      `CHK("ctrl", 6'h0a, rd[5:0])
      `CHK("gain", 1'b1, o_xtal_high_gain)
      `CHK("fxt", 1'b0, o_fast_xtal_en)
      wr(6'h2a);
      `CHK("ctrl", 6'h0a, rd[5:0])
      wr(6'h02);
      `CHK("fxt", 1'b1, o_fast_xtal_en)
      `CHK("frc", 1'b0, o_fast_rc_en)
      `CHK("pins", 1'b1, o_xtal_pins)
      wr(6'h23);
      `CHK("ctrl", 6'h22, rd[5:0])
      `CHK("fast", 1'b1, o_sys_fast)
   endtask : t_slow
   task automatic t_fast();
      wr(6'h29);
      `CHK("ctrl", 6'h23, rd[5:0])
      `CHK("sxt", 1'b1, o_slow_xtal_en)
      wr(6'h16);
      `CHK("ctrl", 6'h16, rd[5:0])
   endtask : t_fast
   task automatic t_modes();
      md(SCKSG_MODE_IDLE);
      `CHK("per", 1'b0, o_periph_clk_en)
      md(SCKSG_MODE_POWER_DOWN_MODE);
      `CHK("src", 1'b0, o_slow_rc_en)
      md(SCKSG_MODE_RUN);
      `CHK("per", 1'b1, o_periph_clk_en)
   endtask : t_modes
   // reset, scenarios, verdict
   initial begin
      repeat (6) @(posedge i_clk_sys);
      i_rstn <= 1'b1;
      @(posedge i_clk_sys);
      t_reset();
      t_slow();
      t_fast();
      t_modes();
      end_of_test();
   end
endmodule : system_clock_select_and_gating_bench
`default_nettype wire
